// *** include/cies_consts.svh ***
/*
 Constants for the instruction execution unit: register byte offsets,
 instruction word fields, flag bit positions and data values.
 Assumes it is included once per file by its bare name.
*/
`ifndef CIES_CONSTS_SVH
`define CIES_CONSTS_SVH

// Register byte offsets on the APB side
`define CIES_ADDR_INSTR 8'h00
`define CIES_ADDR_WORK 8'h04
`define CIES_ADDR_FLAGS 8'h08
`define CIES_ADDR_TBL_LO 8'h0C
`define CIES_ADDR_TBL_HI 8'h10
`define CIES_ADDR_TBL_LATCH 8'h14
`define CIES_ADDR_MEM_PTR 8'h18
`define CIES_ADDR_MEM_DATA 8'h1C
`define CIES_ADDR_STATUS 8'h20

// Instruction register fields
`define CIES_OP_MSB 4
`define CIES_OP_LSB 0
`define CIES_MADDR_MSB 15
`define CIES_MADDR_LSB 8
`define CIES_BIT_MSB 18
`define CIES_BIT_LSB 16
`define CIES_IMM_MSB 31
`define CIES_IMM_LSB 24

// Flag register bit positions
`define CIES_FLAG_W 6
`define CIES_F_CARRY 0
`define CIES_F_NIBBLE 1
`define CIES_F_ZERO 2
`define CIES_F_WRAP 3
`define CIES_F_SIGNED 4
`define CIES_F_CHAIN 5

// Status register bit positions
`define CIES_ST_BUSY 0
`define CIES_ST_SKIPPED 1
`define CIES_ST_CYC_MSB 7
`define CIES_ST_CYC_LSB 4

// Data values
`define CIES_ZERO_BYTE 8'h00
`define CIES_ONE_BYTE 8'h01
`define CIES_ALL_ONES 8'hFF
`define CIES_LAST_PAGE 8'hFF
`define CIES_ZERO_WORD 32'h0000_0000
`define CIES_ZERO_FLAGS 6'h00
`define CIES_ZERO_PADDR 16'h0000
`define CIES_CYC_ONE 4'h1
`define CIES_CYC_ZERO 4'h0
`define CIES_MEM_DEPTH 256

`endif

// *** include/cies_pkg.sv ***
/*
 Types for the instruction execution unit: operation codes and the
 sequencer states. Assumes nothing else; constants live in the header.
*/
package cies_pkg;

   // Operation codes, numbered 0 upward in this order
   typedef enum logic [4:0] {
      OP_NOP,
      OP_SET_BYTE,
      OP_SET_BIT,
      OP_INC_SKIP_IF_NULL,
      OP_INC_TO_WORK_SKIP,
      OP_SKIP_BIT_NONNULL,
      OP_SKIP_IF_NONNULL,
      OP_SUB,
      OP_DIFFERENCE_TO_MEMORY,
      OP_SUB_IMM,
      OP_SWAP,
      OP_NIBBLE_EXCHANGE_TO_WORK,
      OP_SKIP_IF_NULL,
      OP_COPY_SKIP_IF_NULL,
      OP_SKIP_BIT_NULL,
      OP_PAGED_TABLE_READ,
      OP_LAST_PAGE_TABLE_READ,
      OP_INC_PAGED_TABLE_READ,
      OP_INC_LAST_PAGE_TABLE_READ,
      OP_XOR,
      OP_EXCLUSIVE_OR_TO_MEMORY,
      OP_XOR_IMM
   } cies_op_t;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_EXEC,
      ST_TBL_ADDR,
      ST_TBL_DATA,
      ST_DUMMY
   } cies_state_t;

endpackage : cies_pkg

// *** hw/cies_sub.sv ***
/*
 Eight-bit subtractor with the six arithmetic flags.
 Assumes purely combinational use by the execution unit.
*/
`timescale 1ns/1ps
`include "cies_consts.svh"

module cies_sub import cies_pkg::*; (
   input wire logic [7:0] minuend,
   input wire logic [7:0] subtrahend,
   output logic [7:0] diff,
   output logic [`CIES_FLAG_W-1:0] flags
);

   logic [8:0] full;
   logic [4:0] low;

   // Top bit of each wide difference is the borrow out
   assign full = {1'b0, minuend} - {1'b0, subtrahend};
   assign low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
   assign diff = full[7:0];

   // Carry is set when no borrow, i.e. the result is zero or positive
   always_comb begin
      flags = `CIES_ZERO_FLAGS;
      flags[`CIES_F_CARRY] = ~full[8];
      flags[`CIES_F_NIBBLE] = ~low[4];
      flags[`CIES_F_ZERO] = (full[7:0] == `CIES_ZERO_BYTE);
      flags[`CIES_F_WRAP] = (minuend[7] ^ subtrahend[7]) & (full[7] ^ minuend[7]);
      flags[`CIES_F_SIGNED] = full[7] ^ ((minuend[7] ^ subtrahend[7]) & (full[7] ^ minuend[7]));
      // No chained borrow here, so the chained zero follows the plain zero
      flags[`CIES_F_CHAIN] = (full[7:0] == `CIES_ZERO_BYTE);
   end

endmodule : cies_sub

// *** hw/cies_exec.sv ***
/*
 Execution unit for one group of an 8-bit core's instructions: byte and
 bit set, increment/test and skip, subtract, nibble swap, table reads
 and exclusive-OR. Software issues one instruction at a time over APB.
 Assumes a program memory that returns prog_data one cycle after a
 prog_rd pulse, and an APB master with 32-bit data.
*/
`timescale 1ns/1ps
`include "cies_consts.svh"

// Behaviour
// - whole-byte set writes all ones to memory, flags unchanged
// - bit set forces only the selected bit to one, flags unchanged
// - increment memory byte, write back, skip if sum is zero
// - increment into work register, memory kept, skip if zero
// - a taken skip inserts one dummy cycle, making two cycles
// - skip when the selected memory bit is one
// - read and rewrite byte, skip if it is nonzero
// - work minus memory into work, six flags updated
// - carry cleared on negative result, set on zero or positive
// - work minus memory written back to memory, same flags
// - work minus embedded constant into work, same six flags
// - swap nibbles of memory byte in place, no flags
// - nibble-swapped memory byte into work, memory kept
// - read and rewrite byte, skip if it is zero
// - copy memory byte into work, skip if it is zero
// - skip when the selected memory bit is zero
// - paged table read: both pointer bytes, low to memory, high to latch
// - last-page table read uses only low pointer in the final page
// - increment low pointer first, then paged table read
// - increment low pointer first, then last-page read; no flags change
// - work xor memory into work, only zero flag
// - work xor memory back into memory, only zero flag
// - work xor embedded constant into work, only zero flag
module cies_exec import cies_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [15:0] prog_addr,
   output logic prog_rd,
   input wire logic [15:0] prog_data,
   output logic dummy_cycle
);

   cies_state_t state;
   logic [31:0] instr;
   logic [7:0] work_register;
   logic [`CIES_FLAG_W-1:0] flags;
   logic [7:0] table_pointer_low;
   logic [7:0] table_pointer_high;
   logic [7:0] table_high_latch;
   logic [7:0] mem_ptr;
   logic skipped;
   logic [3:0] cycles;
   logic [7:0] dmem [0:`CIES_MEM_DEPTH-1];

   logic busy;
   logic access;
   logic sw_wr;
   logic go;
   cies_op_t op;
   logic [7:0] maddr;
   logic [2:0] bsel;
   logic [7:0] imm;
   logic [7:0] mval;
   logic [7:0] sub_b;
   logic [7:0] sub_diff;
   logic [`CIES_FLAG_W-1:0] sub_flags;
   logic [7:0] next_work;
   logic wr_work;
   logic [7:0] next_mem;
   logic wr_mem;
   logic [`CIES_FLAG_W-1:0] next_flags;
   logic skip;
   logic is_table;
   logic tbl_inc;
   logic tbl_last;
   logic [7:0] next_tbl_low;
   logic [31:0] rd_value;
   logic rd_hit;

   // Zero test shared by skips and the zero flag
   function automatic logic is_null(input logic [7:0] v);
      is_null = (v == `CIES_ZERO_BYTE);
   endfunction : is_null

   // One-hot mask of the selected bit, used by set and both bit tests
   function automatic logic [7:0] bit_mask(input logic [2:0] idx);
      bit_mask = `CIES_ONE_BYTE << idx;
   endfunction : bit_mask

   // Instruction fields
   assign op = cies_op_t'(instr[`CIES_OP_MSB:`CIES_OP_LSB]);
   assign maddr = instr[`CIES_MADDR_MSB:`CIES_MADDR_LSB];
   assign bsel = instr[`CIES_BIT_MSB:`CIES_BIT_LSB];
   assign imm = instr[`CIES_IMM_MSB:`CIES_IMM_LSB];
   assign mval = dmem[maddr];

   // Bus handshake terms; a software write lands only at the pready edge
   assign busy = (state != ST_IDLE);
   assign access = psel & penable & pready;
   assign sw_wr = access & pwrite;
   assign go = sw_wr & (paddr == `CIES_ADDR_INSTR);

   // Subtract operand is the memory byte or the embedded constant
   assign sub_b = (op == OP_SUB_IMM) ? imm : mval;

   cies_sub u_sub (
      .minuend(work_register),
      .subtrahend(sub_b),
      .diff(sub_diff),
      .flags(sub_flags)
   );

   // Operation decode; results are applied only in the execute state
   always_comb begin
      next_work = work_register;
      wr_work = 1'b0;
      next_mem = mval;
      wr_mem = 1'b0;
      next_flags = flags;
      skip = 1'b0;
      is_table = 1'b0;
      tbl_inc = 1'b0;
      tbl_last = 1'b0;
      case (op)
         OP_SET_BYTE: begin
            next_mem = `CIES_ALL_ONES;
            wr_mem = 1'b1;
         end
         OP_SET_BIT: begin
            next_mem = mval | bit_mask(bsel);
            wr_mem = 1'b1;
         end
         OP_INC_SKIP_IF_NULL: begin
            next_mem = mval + `CIES_ONE_BYTE;
            wr_mem = 1'b1;
            skip = is_null(mval + `CIES_ONE_BYTE);
         end
         OP_INC_TO_WORK_SKIP: begin
            next_work = mval + `CIES_ONE_BYTE;
            wr_work = 1'b1;
            skip = is_null(mval + `CIES_ONE_BYTE);
         end
         OP_SKIP_BIT_NONNULL: begin
            skip = |(mval & bit_mask(bsel));
         end
         OP_SKIP_IF_NONNULL: begin
            wr_mem = 1'b1;
            skip = ~is_null(mval);
         end
         OP_SUB, OP_SUB_IMM: begin
            next_work = sub_diff;
            wr_work = 1'b1;
            next_flags = sub_flags;
         end
         OP_DIFFERENCE_TO_MEMORY: begin
            next_mem = sub_diff;
            wr_mem = 1'b1;
            next_flags = sub_flags;
         end
         OP_SWAP: begin
            next_mem = {mval[3:0], mval[7:4]};
            wr_mem = 1'b1;
         end
         OP_NIBBLE_EXCHANGE_TO_WORK: begin
            next_work = {mval[3:0], mval[7:4]};
            wr_work = 1'b1;
         end
         OP_SKIP_IF_NULL: begin
            wr_mem = 1'b1;
            skip = is_null(mval);
         end
         OP_COPY_SKIP_IF_NULL: begin
            next_work = mval;
            wr_work = 1'b1;
            skip = is_null(mval);
         end
         OP_SKIP_BIT_NULL: begin
            skip = ~|(mval & bit_mask(bsel));
         end
         OP_PAGED_TABLE_READ: begin
            is_table = 1'b1;
         end
         OP_LAST_PAGE_TABLE_READ: begin
            is_table = 1'b1;
            tbl_last = 1'b1;
         end
         OP_INC_PAGED_TABLE_READ: begin
            is_table = 1'b1;
            tbl_inc = 1'b1;
         end
         OP_INC_LAST_PAGE_TABLE_READ: begin
            is_table = 1'b1;
            tbl_inc = 1'b1;
            tbl_last = 1'b1;
         end
         OP_XOR: begin
            next_work = work_register ^ mval;
            wr_work = 1'b1;
            next_flags[`CIES_F_ZERO] = is_null(work_register ^ mval);
         end
         OP_EXCLUSIVE_OR_TO_MEMORY: begin
            next_mem = work_register ^ mval;
            wr_mem = 1'b1;
            next_flags[`CIES_F_ZERO] = is_null(work_register ^ mval);
         end
         OP_XOR_IMM: begin
            next_work = work_register ^ imm;
            wr_work = 1'b1;
            next_flags[`CIES_F_ZERO] = is_null(work_register ^ imm);
         end
         default: begin
            // No-op and unused codes change nothing
            wr_mem = 1'b0;
         end
      endcase
   end

   // Pre-increment happens before the address is formed
   assign next_tbl_low = tbl_inc ? (table_pointer_low + `CIES_ONE_BYTE) : table_pointer_low;

   // Sequencer: a taken skip costs one dummy cycle, table reads two more
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (go) begin
                  state <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               if (is_table) begin
                  state <= ST_TBL_ADDR;
               end else if (skip) begin
                  state <= ST_DUMMY;
               end else begin
                  state <= ST_IDLE;
               end
            end
            ST_TBL_ADDR: begin
               state <= ST_TBL_DATA;
            end
            ST_TBL_DATA: begin
               state <= ST_IDLE;
            end
            ST_DUMMY: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Dummy fetch marker and skip record for software
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dummy_cycle <= 1'b0;
         skipped <= 1'b0;
      end else begin
         dummy_cycle <= (state == ST_EXEC) & ~is_table & skip;
         if (go) begin
            skipped <= 1'b0;
         end else if (state == ST_EXEC) begin
            skipped <= skip & ~is_table;
         end
      end
   end

   // Cycles spent on the last instruction: one, two with a skip, or three for a table read
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cycles <= `CIES_CYC_ZERO;
      end else if (go) begin
         cycles <= `CIES_CYC_ZERO;
      end else if (busy) begin
         cycles <= cycles + `CIES_CYC_ONE;
      end
   end

   // Instruction register; the write itself starts execution
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         instr <= `CIES_ZERO_WORD;
      end else if (go) begin
         instr <= pwdata;
      end
   end

   // Work register: software while idle, instruction result in execute
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         work_register <= `CIES_ZERO_BYTE;
      end else if (state == ST_EXEC) begin
         if (wr_work) begin
            work_register <= next_work;
         end
      end else if (sw_wr && paddr == `CIES_ADDR_WORK) begin
         work_register <= pwdata[7:0];
      end
   end

   // Flags: ops that leave them alone pass the old value through
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flags <= `CIES_ZERO_FLAGS;
      end else if (state == ST_EXEC) begin
         flags <= next_flags;
      end else if (sw_wr && paddr == `CIES_ADDR_FLAGS) begin
         flags <= pwdata[`CIES_FLAG_W-1:0];
      end
   end

   // Table pointers; the low byte also takes the pre-increment
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         table_pointer_low <= `CIES_ZERO_BYTE;
         table_pointer_high <= `CIES_ZERO_BYTE;
      end else if (state == ST_EXEC) begin
         table_pointer_low <= next_tbl_low;
      end else if (sw_wr) begin
         if (paddr == `CIES_ADDR_TBL_LO) begin
            table_pointer_low <= pwdata[7:0];
         end
         if (paddr == `CIES_ADDR_TBL_HI) begin
            table_pointer_high <= pwdata[7:0];
         end
      end
   end

   // Program memory request; the last page ignores the high pointer
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prog_addr <= `CIES_ZERO_PADDR;
         prog_rd <= 1'b0;
      end else begin
         prog_rd <= (state == ST_EXEC) & is_table;
         if (state == ST_EXEC && is_table) begin
            if (tbl_last) begin
               prog_addr <= {`CIES_LAST_PAGE, next_tbl_low};
            end else begin
               prog_addr <= {table_pointer_high, next_tbl_low};
            end
         end
      end
   end

   // High byte of the fetched word goes to the latch
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         table_high_latch <= `CIES_ZERO_BYTE;
      end else if (state == ST_TBL_DATA) begin
         table_high_latch <= prog_data[15:8];
      end
   end

   // Software window pointer into data memory
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mem_ptr <= `CIES_ZERO_BYTE;
      end else if (sw_wr && paddr == `CIES_ADDR_MEM_PTR) begin
         mem_ptr <= pwdata[7:0];
      end
   end

   // Data memory has no reset: contents are undefined until written
   always_ff @(posedge clk) begin
      if (state == ST_EXEC && wr_mem) begin
         dmem[maddr] <= next_mem;
      end else if (state == ST_TBL_DATA) begin
         dmem[maddr] <= prog_data[7:0];
      end else if (!busy && sw_wr && paddr == `CIES_ADDR_MEM_DATA) begin
         dmem[mem_ptr] <= pwdata[7:0];
      end
   end

   // Read decode; unmapped offsets answer zero with an error
   always_comb begin
      rd_value = `CIES_ZERO_WORD;
      rd_hit = 1'b1;
      case (paddr)
         `CIES_ADDR_INSTR: rd_value = instr;
         `CIES_ADDR_WORK: rd_value[7:0] = work_register;
         `CIES_ADDR_FLAGS: rd_value[`CIES_FLAG_W-1:0] = flags;
         `CIES_ADDR_TBL_LO: rd_value[7:0] = table_pointer_low;
         `CIES_ADDR_TBL_HI: rd_value[7:0] = table_pointer_high;
         `CIES_ADDR_TBL_LATCH: rd_value[7:0] = table_high_latch;
         `CIES_ADDR_MEM_PTR: rd_value[7:0] = mem_ptr;
         `CIES_ADDR_MEM_DATA: rd_value[7:0] = dmem[mem_ptr];
         `CIES_ADDR_STATUS: begin
            rd_value[`CIES_ST_BUSY] = busy;
            rd_value[`CIES_ST_SKIPPED] = skipped;
            rd_value[`CIES_ST_CYC_MSB:`CIES_ST_CYC_LSB] = cycles;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // APB answer: registered, one cycle after setup, held off while busy
   // so no register can change under a transfer in flight
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
         prdata <= `CIES_ZERO_WORD;
         pslverr <= 1'b0;
      end else if (pready) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (psel && !busy) begin
         pready <= 1'b1;
         prdata <= pwrite ? `CIES_ZERO_WORD : rd_value;
         pslverr <= ~rd_hit;
      end
   end

endmodule : cies_exec

// *** bench/cies_progmem.sv ***
/*
 Program memory model standing behind the execution unit.
 Assumes one prog_rd pulse per table read; the word is due next cycle.
*/
`timescale 1ns/1ps
module cies_progmem (
   input wire logic clk,
   input wire logic prog_rd,
   input wire logic [15:0] prog_addr,
   output logic [15:0] prog_data
);
   // Word valid only in the cycle after the strobe; it toggles otherwise,
   // so a late sample never sees a stale good word
   // One process owns the word, so it has a single driver
   initial begin
      prog_data = 16'hC3A5;
      forever begin
         @(posedge clk);
         if (prog_rd) begin
            prog_data <= {prog_addr[7:0] + 8'h3C, prog_addr[15:8] ^ prog_addr[7:0]};
         end else begin
            prog_data <= ~prog_data;
         end
      end
   end
endmodule : cies_progmem

// *** bench/cies_exec_properties.sv ***
/*
 Port checker for the execution unit.
 Assumes the cies_exec port list; bound at the foot of this file.
*/
`timescale 1ns/1ps
module cies_exec_properties (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [15:0] prog_addr,
   input wire logic prog_rd,
   input wire logic [15:0] prog_data,
   input wire logic dummy_cycle
);
   logic go, skip_go, tbl_go, last_paged;
   logic [7:0] tlo, thi;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Instruction launch decode
   assign go = psel && penable && pready && pwrite && paddr == 8'h00;
   assign skip_go = go && pwdata[4:0] inside {3, 4, 5, 6, 12, 13, 14};
   assign tbl_go = go && pwdata[4:0] inside {[15:18]};
   // Pointer shadow; bus is stalled while busy so no race with the unit
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tlo <= 8'h00;
         thi <= 8'h00;
         last_paged <= 1'b0;
      end else if (tbl_go) begin
         tlo <= (pwdata[4:0] > 5'h10) ? tlo + 8'h01 : tlo;
         last_paged <= pwdata[0];
      end else if (psel && penable && pready && pwrite && paddr == 8'h0C) begin
         tlo <= pwdata[7:0];
      end else if (psel && penable && pready && pwrite && paddr == 8'h10) begin
         thi <= pwdata[7:0];
      end
   end
   sequence s_plain_go; go && !skip_go; endsequence
   sequence s_tbl_walk; ##2 prog_rd ##1 !prog_rd; endsequence
   property p_dummy_pulse; dummy_cycle |=> !dummy_cycle; endproperty
   property p_dummy_cause; dummy_cycle |-> $past(skip_go, 2); endproperty
   property p_no_dummy; s_plain_go |-> ##2 !dummy_cycle; endproperty
   property p_tbl_walk; tbl_go |-> s_tbl_walk; endproperty
   property p_rd_cause; prog_rd |-> $past(tbl_go, 2); endproperty
   property p_paged; prog_rd && last_paged |-> prog_addr == {thi, tlo}; endproperty
   property p_last; prog_rd && !last_paged |-> prog_addr == {8'hFF, tlo}; endproperty
   property p_rd_no_dummy; prog_rd |-> !dummy_cycle throughout ##1 1'b1; endproperty
   a_dummy_pulse: assert property (p_dummy_pulse) else $error("dummy too long");
   a_dummy_cause: assert property (p_dummy_cause) else $error("stray dummy");
   a_no_dummy: assert property (p_no_dummy) else $error("dummy on plain op");
   a_tbl_walk: assert property (p_tbl_walk) else $error("no table strobe");
   a_rd_cause: assert property (p_rd_cause) else $error("stray strobe");
   a_paged: assert property (p_paged) else $error("paged address");
   a_last: assert property (p_last) else $error("last page address");
   a_rd_no_dummy: assert property (p_rd_no_dummy) else $error("table skip");
endmodule : cies_exec_properties

bind cies_exec cies_exec_properties u_props (.clk(clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr), .prog_rd(prog_rd),
   .prog_data(prog_data), .dummy_cycle(dummy_cycle));

// *** bench/tb_top.sv ***
/*
 Self-checking bench for the execution unit: integer model per instruction.
 Assumes cies_exec, the program memory model and the bound checker.
*/
`timescale 1ns/1ps
module tb_top;
   logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, prog_rd, dummy_cycle, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] prog_addr, prog_data;
   int fail_count, check_count, cyc, dcnt, op;
   cies_exec DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_data(prog_data),
      .dummy_cycle(dummy_cycle));
   cies_progmem u_pm (.clk(clk), .prog_rd(prog_rd), .prog_addr(prog_addr),
      .prog_data(prog_data));
   // Clock, 20 ns period
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Cycle ceiling and dummy pulse count
   always @(posedge clk) begin
      cyc++;
      dcnt += (dummy_cycle === 1'b1);
      if (cyc == 40000) begin
         fail_count++;
         tally_and_finish;
      end
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [32:0] g, input logic [32:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %0t op %0d got %0h exp %0h", $time, op, g, e);
      end
   endtask : chk
   // One APB transfer; waits for pready however long the unit stalls
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   function automatic int subf(int a, int s);
      int r, z, o;
      r = (a - s) & 255;
      z = r == 0;
      o = ((a ^ s) & (a ^ r) & 128) != 0;
      return (a >= s) | ((a & 15) >= (s & 15)) << 1 | z << 2 | o << 3
         | (((r >> 7) ^ o) & 1) << 4 | z << 5;
   endfunction : subf
   // Main sequence: every op code many times with random operands
   initial begin
      int w, v, m, b, imm, f, lo, hi, s, ew, ev, ef, el, sk, cy, d0, pa;
      {sys_rst, psel, penable, pwrite, paddr, pwdata} = {3'b100, 1'b0, 8'h00, 32'h0};
      el = 0;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      s = $urandom(89);
      apb(1'b0, 8'h04, 0);
      chk(rd, 0);
      apb(1'b0, 8'h24, 0);
      chk({er, rd}, 33'h1_0000_0000);
      // The last passes use the unused codes, which must change nothing
      for (int i = 0; i < 184; i++) begin
         op = i < 176 ? i % 22 : 22 + $urandom_range(9);
         {m, b, imm, f, lo, hi} = {$urandom_range(255), $urandom_range(7),
            $urandom_range(255), $urandom_range(63), $urandom_range(255), $urandom_range(255)};
         s = $urandom_range(3);
         v = s == 0 ? 0 : s == 1 ? 255 : $urandom_range(255);
         w = $urandom_range(2) == 0 ? v : $urandom_range(255);
         apb(1'b1, 8'h18, m);
         apb(1'b1, 8'h1C, v);
         apb(1'b1, 8'h04, w);
         apb(1'b1, 8'h08, f);
         apb(1'b1, 8'h0C, lo);
         apb(1'b1, 8'h10, hi);
         {ew, ev, ef, sk, cy} = {w, v, f, 0, 1};
         s = op == 9 || op == 21 ? imm : v;
         case (op)
            1: ev = 255;
            2: ev = v | (1 << b);
            3: ev = (v + 1) & 255;
            4: ew = (v + 1) & 255;
            5: sk = (v >> b) & 1;
            6: sk = v != 0;
            7, 9: ew = (w - s) & 255;
            8: ev = (w - s) & 255;
            10: ev = ((v << 4) | (v >> 4)) & 255;
            11: ew = ((v << 4) | (v >> 4)) & 255;
            12: sk = v == 0;
            13: {ew, sk} = {v, int'(v == 0)};
            14: sk = ((v >> b) & 1) == 0;
            19, 21: ew = w ^ s;
            20: ev = w ^ s;
            default: ;
         endcase
         if (op == 3 || op == 4) sk = (v + 1) % 256 == 0;
         if (op >= 7 && op <= 9) ef = subf(w, s);
         if (op >= 19 && op <= 21) ef = (f & 59) | (((w ^ s) == 0) << 2);
         if (op >= 15 && op <= 18) begin
            lo = op > 16 ? (lo + 1) & 255 : lo;
            pa = (op % 2 ? hi : 255) * 256 + lo;
            {ev, el, cy} = {(pa >> 8 ^ pa) & 255, (lo + 60) & 255, 3};
         end
         cy = sk ? 2 : cy;
         d0 = dcnt;
         apb(1'b1, 8'h00, {imm[7:0], 5'h0, b[2:0], m[7:0], 3'h0, op[4:0]});
         apb(1'b0, 8'h04, 0);
         chk(rd, ew);
         apb(1'b0, 8'h08, 0);
         chk(rd, ef);
         apb(1'b0, 8'h1C, 0);
         chk(rd, ev);
         apb(1'b0, 8'h14, 0);
         chk(rd, el);
         apb(1'b0, 8'h0C, 0);
         chk(rd, lo);
         apb(1'b0, 8'h20, 0);
         chk({rd[7:4], rd[1]}, {cy[3:0], sk[0]});
         chk(dcnt - d0, sk);
      end
      tally_and_finish;
   end
endmodule : tb_top
